//--- reset_init_pkg.sv
// Constants shared by the reset state initialiser: widths, field positions, reset values.
// Assumes a single system clock domain and an AHB-Lite register slave.
`default_nettype none
package reset_init_pkg;
  localparam int unsigned PC_W = 13;
  localparam int unsigned SP_W = 4;
  localparam logic [3:0] SP_TOP = 4'hF;
  localparam logic [7:0] PCL_CLEAR = 8'h00;
  localparam logic [7:0] PORT_ALL_INPUT = 8'hFF;
  localparam logic [7:0] PORT_PULLUP_RST = 8'h00;
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
  localparam logic [7:0] WDOG_CTRL_RST = 8'h53;
  localparam logic [7:0] LV_SEL_RST = 8'h66;
  // Status register field positions.
  localparam int unsigned STAT_PDF_BIT = 4;
  localparam int unsigned STAT_TO_BIT = 5;
  // Reset cause one-hot bit positions.
  localparam int unsigned CAUSE_POR = 0;
  localparam int unsigned CAUSE_LVR = 1;
  localparam int unsigned CAUSE_WDT_RUN = 2;
  localparam int unsigned CAUSE_WDT_SLEEP = 3;
  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CAUSE = 8'h04;
  localparam logic [7:0] ADDR_EVT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_LVSEL = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_PORT = 8'h18;
  localparam logic [7:0] ADDR_WDOG = 8'h1C;
  localparam logic [7:0] ADDR_SPPC = 8'h20;
  localparam logic [3:0] EVT_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_APPLY = 3'b010,
    ST_RUN = 3'b100
  } seq_state_t;
endpackage : reset_init_pkg
`default_nettype wire

//--- reset_state_initializer.sv
// Reset state initialiser: applies per-cause initial values to core state on a reset request.
// Assumes request pulses are synchronous to mclk_i and an AHB-Lite master on the register port.
//
// Summary of operation
// - Watchdog timeout in sleep/idle zeroes PC and SP, sets both flags, keeps rest.
// - Power-on clears both flags; low-voltage reset keeps both flags.
// - Watchdog timeout in run sets timeout flag, keeps powerdown flag.
// - After sleep/idle watchdog reset both flags read as one.
// - Both flags live in the status register, set by sleep entry and watchdog.
// - Power-on reset clears int_ctrl_o to disable all interrupt sources; the event mask behind irq_o keeps its value.
// - Power-on clears watchdog and time base counters; watchdog restarts counting.
// - Power-on reset switches all timer modules off.
// - Power-on sets port and port-direction registers to all ones.
// - Power-on puts stack pointer at top and program counter at zero.
// - Full resets load defaults; sleep watchdog reset keeps registers, clears PC and SP.
// - A genuine low-voltage reset keeps the threshold selection register.
`default_nettype none
module reset_state_initializer (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic por_req_i,
  input wire logic lvr_req_i,
  input wire logic wdt_req_i,
  input wire logic sleep_i,
  input wire logic sleep_entry_i,
  input wire logic clr_wdt_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hsel_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic irq_o,
  output logic core_hold_o,
  output logic [12:0] pc_o,
  output logic [3:0] sp_o,
  output logic watchdog_timeout_flag_o,
  output logic powerdown_flag_o,
  output logic [7:0] int_ctrl_o,
  output logic [7:0] timer_ctrl_o,
  output logic [7:0] port_data_o,
  output logic [7:0] port_dir_o,
  output logic [7:0] lv_threshold_select_o,
  output logic [7:0] watchdog_control_reg_o,
  output logic [15:0] watchdog_timer_o,
  output logic [15:0] timebase_cnt_o
);

  // Full reset causes load the defined defaults; the sleep watchdog cause does not.
  function automatic logic full_reset(input logic [3:0] c);
    full_reset = c[reset_init_pkg::CAUSE_POR] | c[reset_init_pkg::CAUSE_LVR]
               | c[reset_init_pkg::CAUSE_WDT_RUN];
  endfunction : full_reset

  // Architectural state, one flop per field.
  reset_init_pkg::seq_state_t state_reg;
  reset_init_pkg::seq_state_t state_next;
  logic core_hold_reg;
  logic [3:0] cause_reg;
  logic [12:0] pc_reg;
  logic [3:0] sp_reg;
  logic to_reg;
  logic pdf_reg;
  logic [7:0] int_reg;
  logic [7:0] tmr_reg;
  logic [7:0] port_reg;
  logic [7:0] dir_reg;
  logic [7:0] lvsel_reg;
  logic [7:0] wdc_reg;
  logic [15:0] wdt_cnt_reg;
  logic [15:0] tb_cnt_reg;
  logic [3:0] evt_reg;
  logic [3:0] mask_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic [7:0] a_addr_reg;
  logic a_wr_reg;
  logic a_rd_reg;

  // Prioritised one-hot cause of the incoming request.
  wire logic any_req = por_req_i | lvr_req_i | wdt_req_i;
  wire logic [3:0] cause_new;
  assign cause_new[reset_init_pkg::CAUSE_POR] = por_req_i;
  assign cause_new[reset_init_pkg::CAUSE_LVR] = ~por_req_i & lvr_req_i;
  assign cause_new[reset_init_pkg::CAUSE_WDT_RUN] = ~por_req_i & ~lvr_req_i
                                                  & wdt_req_i & ~sleep_i;
  assign cause_new[reset_init_pkg::CAUSE_WDT_SLEEP] = ~por_req_i & ~lvr_req_i
                                                    & wdt_req_i & sleep_i;
  wire logic apply = (state_reg == reset_init_pkg::ST_APPLY);
  wire logic c_por = cause_reg[reset_init_pkg::CAUSE_POR];
  wire logic c_lvr = cause_reg[reset_init_pkg::CAUSE_LVR];
  wire logic c_wrun = cause_reg[reset_init_pkg::CAUSE_WDT_RUN];
  wire logic c_wslp = cause_reg[reset_init_pkg::CAUSE_WDT_SLEEP];
  wire logic c_full = full_reset(cause_reg);

  // Bus decode: a transfer is taken when selected, NONSEQ or SEQ (htrans bit 1 set) and the bus is ready.
  wire logic take = hsel_i & hready_i & htrans_i[1];
  wire logic wr_st = a_wr_reg & (a_addr_reg == reset_init_pkg::ADDR_STATUS);
  wire logic wr_mask = a_wr_reg & (a_addr_reg == reset_init_pkg::ADDR_MASK);
  wire logic wr_lvs = a_wr_reg & (a_addr_reg == reset_init_pkg::ADDR_LVSEL);
  wire logic wr_ctrl = a_wr_reg & (a_addr_reg == reset_init_pkg::ADDR_CTRL);
  wire logic wr_port = a_wr_reg & (a_addr_reg == reset_init_pkg::ADDR_PORT);
  wire logic wr_wdc = a_wr_reg & (a_addr_reg == reset_init_pkg::ADDR_WDOG);
  wire logic rd_evt = a_rd_reg & (a_addr_reg == reset_init_pkg::ADDR_EVT);
  wire logic [3:0] evt_set = apply ? cause_reg : 4'h0;

  // Read words are picked in the address phase so that hrdata stands in the data phase.
  wire logic [7:0] ra = haddr_i[7:0];
  wire logic [31:0] status_word = {26'h0000000, to_reg, pdf_reg, 4'h0};
  wire logic [31:0] cause_word = {28'h0000000, cause_reg};
  wire logic [31:0] evt_word = {28'h0000000, evt_reg};
  wire logic [31:0] mask_word = {28'h0000000, mask_reg};
  wire logic [31:0] lvsel_word = {24'h000000, lvsel_reg};
  wire logic [31:0] ctrl_word = {16'h0000, tmr_reg, int_reg};
  wire logic [31:0] port_word = {16'h0000, dir_reg, port_reg};
  wire logic [31:0] wdog_word = {8'h00, wdt_cnt_reg, wdc_reg};
  wire logic [31:0] sppc_word = {15'h0000, sp_reg, pc_reg};
  wire logic [31:0] rd_mux =
    (ra == reset_init_pkg::ADDR_STATUS) ? status_word :
    (ra == reset_init_pkg::ADDR_CAUSE) ? cause_word :
    (ra == reset_init_pkg::ADDR_EVT) ? evt_word :
    (ra == reset_init_pkg::ADDR_MASK) ? mask_word :
    (ra == reset_init_pkg::ADDR_LVSEL) ? lvsel_word :
    (ra == reset_init_pkg::ADDR_CTRL) ? ctrl_word :
    (ra == reset_init_pkg::ADDR_PORT) ? port_word :
    (ra == reset_init_pkg::ADDR_WDOG) ? wdog_word :
    (ra == reset_init_pkg::ADDR_SPPC) ? sppc_word : 32'h0000_0000;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      reset_init_pkg::ST_IDLE: state_next = reset_init_pkg::ST_RUN;
      reset_init_pkg::ST_APPLY: state_next = reset_init_pkg::ST_RUN;
      reset_init_pkg::ST_RUN: if (any_req) state_next = reset_init_pkg::ST_APPLY;
      default: state_next = reset_init_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= reset_init_pkg::ST_IDLE;
      cause_reg <= 4'h1;
    end else begin
      state_reg <= state_next;
      if (state_reg == reset_init_pkg::ST_RUN && any_req) cause_reg <= cause_new;
    end
  end

  // The hold output has its own flop so that the core never sees decode glitches.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_hold_reg <= 1'b1;
    end else begin
      core_hold_reg <= (state_next != reset_init_pkg::ST_RUN);
    end
  end

  // Program counter and stack pointer.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc_reg <= 13'h0000;
      sp_reg <= reset_init_pkg::SP_TOP;
    end else if (apply) begin
      pc_reg <= 13'h0000;
      sp_reg <= c_wslp ? 4'h0 : reset_init_pkg::SP_TOP;
    end
  end

  // Reset flags; hardware set wins over a software write in the same cycle.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      to_reg <= 1'b0;
      pdf_reg <= 1'b0;
    end else if (apply) begin
      to_reg <= c_por ? 1'b0 : (c_lvr ? to_reg : 1'b1);
      pdf_reg <= c_por ? 1'b0 : (c_wslp ? 1'b1 : pdf_reg);
    end else if (sleep_entry_i) begin
      pdf_reg <= 1'b1;
      to_reg <= 1'b0;
    end else if (clr_wdt_i) begin
      pdf_reg <= 1'b0;
      to_reg <= 1'b0;
    end else if (wr_st) begin
      to_reg <= hwdata_i[reset_init_pkg::STAT_TO_BIT];
      pdf_reg <= hwdata_i[reset_init_pkg::STAT_PDF_BIT];
    end
  end

  // Interrupt, timer, port and watchdog control defaults; bus writes lose to an apply cycle.
  wire logic load_defaults = apply & c_full;
  wire logic wr_ctrl_ok = ~apply & wr_ctrl;
  wire logic wr_port_ok = ~apply & wr_port;
  wire logic wr_wdc_ok = ~apply & wr_wdc;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_reg <= reset_init_pkg::INT_CTRL_RST;
    end else if (load_defaults) begin
      int_reg <= reset_init_pkg::INT_CTRL_RST;
    end else if (wr_ctrl_ok) begin
      int_reg <= hwdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_reg <= reset_init_pkg::TIMER_CTRL_RST;
    end else if (load_defaults) begin
      tmr_reg <= reset_init_pkg::TIMER_CTRL_RST;
    end else if (wr_ctrl_ok) begin
      tmr_reg <= hwdata_i[15:8];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_reg <= reset_init_pkg::PORT_ALL_INPUT;
    end else if (load_defaults) begin
      port_reg <= reset_init_pkg::PORT_ALL_INPUT;
    end else if (wr_port_ok) begin
      port_reg <= hwdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_reg <= reset_init_pkg::PORT_ALL_INPUT;
    end else if (load_defaults) begin
      dir_reg <= reset_init_pkg::PORT_ALL_INPUT;
    end else if (wr_port_ok) begin
      dir_reg <= hwdata_i[15:8];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdc_reg <= reset_init_pkg::WDOG_CTRL_RST;
    end else if (load_defaults) begin
      wdc_reg <= reset_init_pkg::WDOG_CTRL_RST;
    end else if (wr_wdc_ok) begin
      wdc_reg <= hwdata_i[7:0];
    end
  end

  // Threshold selection survives a genuine low-voltage reset and a sleep watchdog reset.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvsel_reg <= reset_init_pkg::LV_SEL_RST;
    end else if (apply && (c_por || c_wrun)) begin
      lvsel_reg <= reset_init_pkg::LV_SEL_RST;
    end else if (!apply && wr_lvs) begin
      lvsel_reg <= hwdata_i[7:0];
    end
  end

  // Counters restart from zero at once after a full reset, so the watchdog keeps running.
  wire logic wdt_restart = load_defaults | clr_wdt_i;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdt_cnt_reg <= 16'h0000;
    end else if (wdt_restart) begin
      wdt_cnt_reg <= 16'h0000;
    end else begin
      wdt_cnt_reg <= wdt_cnt_reg + 16'h0001;
    end
  end

  // The time base is cleared only by a full reset; a watchdog clear leaves it running.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tb_cnt_reg <= 16'h0000;
    end else if (load_defaults) begin
      tb_cnt_reg <= 16'h0000;
    end else begin
      tb_cnt_reg <= tb_cnt_reg + 16'h0001;
    end
  end

  // Sticky cause events, cleared by reading; a new event wins over the clearing read.
  wire logic [3:0] evt_next = (rd_evt ? 4'h0 : evt_reg) | evt_set;
  wire logic irq_next = |(evt_next & mask_reg);
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_reg <= reset_init_pkg::EVT_RST;
    end else begin
      evt_reg <= evt_next;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_reg <= reset_init_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= hwdata_i[3:0];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY, unmapped reads return zero.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      a_addr_reg <= 8'h00;
      a_wr_reg <= 1'b0;
      a_rd_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      a_addr_reg <= haddr_i[7:0];
      a_wr_reg <= take & hwrite_i;
      a_rd_reg <= take & ~hwrite_i;
      if (take && !hwrite_i) rdata_reg <= rd_mux;
    end
  end

  assign hrdata_o = rdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign irq_o = irq_reg;
  assign core_hold_o = core_hold_reg;
  assign pc_o = pc_reg;
  assign sp_o = sp_reg;
  assign watchdog_timeout_flag_o = to_reg;
  assign powerdown_flag_o = pdf_reg;
  assign int_ctrl_o = int_reg;
  assign timer_ctrl_o = tmr_reg;
  assign port_data_o = port_reg;
  assign port_dir_o = dir_reg;
  assign lv_threshold_select_o = lvsel_reg;
  assign watchdog_control_reg_o = wdc_reg;
  assign watchdog_timer_o = wdt_cnt_reg;
  assign timebase_cnt_o = tb_cnt_reg;

endmodule : reset_state_initializer
`default_nettype wire

//--- reset_init_sva.sv
// Checker: outcome of each taken reset request at the initialiser's ports.
// Assumes one clock domain and reset requests synchronous to mclk_i.
`default_nettype none
module reset_init_sva (
  input wire logic mclk_i, nrst_i, por_req_i, lvr_req_i, wdt_req_i, sleep_i, sleep_entry_i,
  input wire logic clr_wdt_i, core_hold_o, watchdog_timeout_flag_o, powerdown_flag_o,
  input wire logic [12:0] pc_o,
  input wire logic [3:0] sp_o,
  input wire logic [7:0] int_ctrl_o, timer_ctrl_o, port_data_o, lv_threshold_select_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // Lower-priority causes are judged only when no power-on request competes.
  wire run = !core_hold_o && !por_req_i;
  wire quiet = run && !lvr_req_i && !wdt_req_i;
  wire calm = run && !sleep_entry_i && !clr_wdt_i;
  wire [1:0] flg = {watchdog_timeout_flag_o, powerdown_flag_o};
  AST_POR_CORE: assert property (!core_hold_o && por_req_i |=> ##1 flg == 2'h0
    && sp_o == 4'hF && pc_o == 13'h0000) else $error("power-on core state wrong");
  AST_POR_CTRL: assert property (!core_hold_o && por_req_i |=> ##1 int_ctrl_o == 8'h00
    && timer_ctrl_o == 8'h00 && port_data_o == 8'hFF) else $error("power-on controls wrong");
  AST_LVR_KEEP: assert property (calm && lvr_req_i |=> ##1 flg == $past(flg, 2)
    && lv_threshold_select_o == $past(lv_threshold_select_o, 2)) else $error("lvr lost state");
  AST_WDT_RUN: assert property (calm && !lvr_req_i && wdt_req_i && !sleep_i |=> ##1
    watchdog_timeout_flag_o && powerdown_flag_o == $past(powerdown_flag_o, 2)
    && lv_threshold_select_o == 8'h66) else $error("run watchdog reset wrong");
  AST_WDT_SLEEP: assert property (run && !lvr_req_i && wdt_req_i && sleep_i |=> ##1
    flg == 2'h3 && {sp_o, pc_o} == 17'h00000 && int_ctrl_o == $past(int_ctrl_o, 2))
    else $error("sleep watchdog reset wrong");
  AST_ENTRY: assert property (quiet && sleep_entry_i && !clr_wdt_i |=> flg == 2'h1)
    else $error("sleep entry flags wrong");
  AST_CLR: assert property (quiet && clr_wdt_i && !sleep_entry_i |=> flg == 2'h0)
    else $error("watchdog clear flags wrong");
  AST_HOLD: assert property (!core_hold_o && (por_req_i || !quiet) |=> core_hold_o
    ##1 !core_hold_o) else $error("apply phase not one cycle");
  cover property (run && lvr_req_i);
  cover property (run && wdt_req_i && sleep_i);
  cover property (!core_hold_o && por_req_i && lvr_req_i);
endmodule : reset_init_sva
bind reset_state_initializer reset_init_sva u_sva (.mclk_i, .nrst_i, .por_req_i, .lvr_req_i,
  .wdt_req_i, .sleep_i, .sleep_entry_i, .clr_wdt_i, .core_hold_o, .watchdog_timeout_flag_o,
  .powerdown_flag_o, .pc_o, .sp_o, .int_ctrl_o, .timer_ctrl_o, .port_data_o,
  .lv_threshold_select_o);
`default_nettype wire

//--- reset_state_initializer_tb_top.sv
// Bench for the reset state initialiser: each reset cause, flags, bus and interrupt.
// Assumes the one AHB-Lite slave's hreadyout is the bus hready.
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module reset_state_initializer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, nrst, por, low_voltage_reset, wdt, slp, ent, clr, hw, hsel, hrdy, hresp, irq, to_f, pd_f, hold;
  logic [1:0] htr;
  logic [31:0] ha, hwd, hrd, rd;
  logic [12:0] pc;
  logic [3:0] sp;
  logic [7:0] intc, tmr, pdat, pdir, lvs, wctl;
  logic [15:0] wcnt, tbc;
  int n_fail = 0, n_compared = 0;
  reset_state_initializer u_dut (.mclk_i(mclk), .nrst_i(nrst), .por_req_i(por), .lvr_req_i(low_voltage_reset),
    .wdt_req_i(wdt), .sleep_i(slp), .sleep_entry_i(ent), .clr_wdt_i(clr), .haddr_i(ha),
    .htrans_i(htr), .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hwd), .hsel_i(hsel),
    .hready_i(hrdy), .hrdata_o(hrd), .hreadyout_o(hrdy), .hresp_o(hresp), .irq_o(irq),
    .core_hold_o(hold), .pc_o(pc), .sp_o(sp), .watchdog_timeout_flag_o(to_f),
    .powerdown_flag_o(pd_f), .int_ctrl_o(intc), .timer_ctrl_o(tmr), .port_data_o(pdat),
    .port_dir_o(pdir), .lv_threshold_select_o(lvs), .watchdog_control_reg_o(wctl),
    .watchdog_timer_o(wcnt), .timebase_cnt_o(tbc));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {hsel, htr, hw, ha} <= {1'h1, 2'h2, w, 24'h000000, a};
    do @(posedge mclk); while (hrdy !== 1'h1);
    {hsel, htr, hwd} <= {1'h0, 2'h0, d};
    do @(posedge mclk); while (hrdy !== 1'h1);
    rd = hrd;
    #1;
  endtask : bus
  // Bits are por, lvr, wdt, sleep, sleep entry, clear; loaded values show two edges later.
  task automatic drive(input logic [5:0] v);
    @(posedge mclk);
    {por, low_voltage_reset, wdt, slp, ent, clr} <= v;
    @(posedge mclk);
    {por, low_voltage_reset, wdt, slp, ent, clr} <= 6'h00;
    #101;
  endtask : drive
  task automatic t_defaults;
    `CHK("core", {13'h0000, 4'hF, 2'h0}, {pc, sp, to_f, pd_f})
    `CHK("controls", 64'h0000FFFF00010001, {intc, tmr, pdir, pdat, wcnt, tbc})
    `CHK("hold", 1'h0, hold)
    bus(1'h0, 8'h1C, 32'h0);
    `CHK("wdog ctrl", 8'h53, rd[7:0])
    bus(1'h0, 8'h40, 32'h0);
    `CHK("unmapped", 33'h000000000, {hresp, rd})
  endtask : t_defaults
  task automatic t_lvr;
    bus(1'h1, 8'h10, 32'h55);
    bus(1'h1, 8'h18, 32'h0);
    bus(1'h1, 8'h0C, 32'hF);
    drive(6'h02);
    `CHK("entry flags", 2'h1, {to_f, pd_f})
    drive(6'h10);
    `CHK("lvr state", {8'h55, 2'h1, 16'hFFFF}, {lvs, to_f, pd_f, pdir, pdat})
    #50;
    `CHK("irq set", 1'h1, irq)
    bus(1'h0, 8'h08, 32'h0);
    `CHK("lvr event", 4'h2, rd[3:0])
    #100;
    `CHK("irq clear", 1'h0, irq)
  endtask : t_lvr
  task automatic t_watchdog;
    drive(6'h08);
    `CHK("run wdt", {2'h3, 8'h66}, {to_f, pd_f, lvs})
    bus(1'h0, 8'h08, 32'h0);
    `CHK("run event", 4'h4, rd[3:0])
    bus(1'h0, 8'h00, 32'h0);
    `CHK("status", 2'h3, {rd[5], rd[4]})
    drive(6'h01);
    `CHK("cleared", 2'h0, {to_f, pd_f})
    bus(1'h1, 8'h14, 32'hA5C3);
    bus(1'h1, 8'h1C, 32'h2A);
    drive(6'h0C);
    `CHK("sleep wdt", {17'h00000, 2'h3}, {sp, pc, to_f, pd_f})
    `CHK("kept", 24'hA5C32A, {tmr, intc, wctl})
    bus(1'h0, 8'h08, 32'h0);
    `CHK("sleep event", 4'h8, rd[3:0])
  endtask : t_watchdog
  task automatic t_por;
    bus(1'h1, 8'h0C, 32'h0);
    drive(6'h38);
    `CHK("por", {4'hF, 2'h0, 16'h0000, 16'h6653}, {sp, to_f, pd_f, intc, tmr, lvs, wctl})
    `CHK("por counters", 32'h00010001, {wcnt, tbc})
    #50;
    `CHK("irq masked", 1'h0, irq)
    bus(1'h0, 8'h08, 32'h0);
    `CHK("por event", 4'h1, rd[3:0])
  endtask : t_por
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // Normal runs take about 80 cycles, so this only trips on a hang.
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
  initial begin
    {por, low_voltage_reset, wdt, slp, ent, clr, hw, hsel} = 8'h00;
    {htr, ha, hwd} = 66'h0;
    nrst = 1'h0;
    repeat (12) @(posedge mclk);
    nrst <= 1'h1;
    #51;
    t_defaults();
    t_lvr();
    t_watchdog();
    t_por();
    give_verdict();
  end
endmodule : reset_state_initializer_tb_top
`default_nettype wire
